// ---- include/cmt_pkg.sv ----
`default_nettype none

package cmt_pkg;

// ============================================================
// Sizes
localparam int unsigned NCH = 4;
localparam int unsigned AW = 8;

// ============================================================
// Register offsets (byte addresses, one word each)
localparam logic [7:0] ADDR_CTRL = 8'h00;
localparam logic [7:0] ADDR_TC = 8'h04;
localparam logic [7:0] ADDR_PR = 8'h08;
localparam logic [7:0] ADDR_PC = 8'h0c;
localparam logic [7:0] ADDR_MCR = 8'h10;
localparam logic [7:0] ADDR_EMR = 8'h14;
localparam logic [7:0] ADDR_CCR = 8'h18;
localparam logic [7:0] ADDR_STAT = 8'h1c;
localparam logic [7:0] ADDR_MASK = 8'h20;
localparam logic [7:0] ADDR_MR0 = 8'h24;
localparam logic [7:0] ADDR_CR0 = 8'h34;
localparam logic [7:0] ADDR_STEP = 8'h04;

// ============================================================
// Field positions
localparam int unsigned CTRL_EN_BIT = 0;
localparam int unsigned CTRL_RST_BIT = 1;
localparam int unsigned MCR_INT_BIT = 0;
localparam int unsigned MCR_RST_BIT = 1;
localparam int unsigned MCR_STOP_BIT = 2;
localparam int unsigned MCR_W = 3;
localparam int unsigned CCR_RISE_BIT = 0;
localparam int unsigned CCR_FALL_BIT = 1;
localparam int unsigned CCR_INT_BIT = 2;
localparam int unsigned CCR_W = 3;
localparam int unsigned EMR_W = 2;
localparam int unsigned EMR_OUT_LSB = 8;
localparam int unsigned STAT_MATCH_LSB = 0;
localparam int unsigned STAT_CAP_LSB = 4;

// ============================================================
// Match output actions
typedef enum logic [1:0] {
    MO_NONE = 2'b00,
    MO_LOW = 2'b01,
    MO_HIGH = 2'b10,
    MO_TOGGLE = 2'b11
} match_act_t;

// ============================================================
// Carriers and state
typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
} reg_req_t;

typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
} sync_state_t;

typedef struct packed {
    logic [31:0] tc;
    logic [31:0] pc;
    logic [31:0] pr;
    logic en;
    logic crst;
    logic [11:0] mcr;
    logic [7:0] emr;
    logic [11:0] ccr;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [3:0][31:0] mr;
    logic [3:0][31:0] cr;
    logic [3:0] mo;
    logic [31:0] rdata;
    logic irq;
} tmr_state_t;

// ============================================================
// Reset values
localparam sync_state_t SYNC_RST = '0;
localparam tmr_state_t TMR_RST = '0;

endpackage

`default_nettype wire

// ---- logic/capture_match_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - 32-bit count advanced by 32-bit prescaler
// - Both counters step only on timer clock
// - Register port separate from counting rate
// - Four channels copy count on input edge
// - Capture may raise interrupt per channel
// - Match compares count, optional interrupt
// - Match may stop the counter
// - Match may reset counter to zero
// - Match output: low, high, toggle, none
module capture_match_timer (
    input wire logic i_sys_clk, // 125 MHz system clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_tmr_tick, // Timer branch clock enable
    input wire cmt_pkg::reg_req_t i_bus, // Register request
    input wire logic [3:0] i_capture_input, // Capture inputs
    output logic [31:0] o_rd_data, // Read data, cycle after read
    output logic o_irq, // Interrupt, level
    output logic [3:0] o_match_output // Match outputs
);

    cmt_pkg::tmr_state_t q;
    cmt_pkg::tmr_state_t nxt_q;
    logic [3:0] cap_rise;
    logic [3:0] cap_fall;
    logic [3:0] cap_hit;
    logic [3:0] hit;
    logic [3:0] hit_rst;
    logic [3:0] hit_stop;
    logic [3:0] hit_int;
    logic wrap;
    logic cnt_run;
    logic [31:0] rd_val;

    // ============================================================
    // Capture input conditioning
    for (genvar g = 0; g < cmt_pkg::NCH; g++) begin : g_cap
        capture_sync u_sync (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_tick(i_tmr_tick),
            .i_in(i_capture_input[g]),
            .o_rise(cap_rise[g]),
            .o_fall(cap_fall[g])
        );
    end

    // ============================================================
    // Count qualifiers and match decode
    // Matches are judged only on the tick that would step the count
    always_comb begin
        cnt_run = q.en && !q.crst && i_tmr_tick;
        wrap = cnt_run && (q.pc == q.pr);
        for (int i = 0; i < cmt_pkg::NCH; i++) begin
            hit[i] = wrap && (q.tc == q.mr[i]);
            hit_int[i] = hit[i] && q.mcr[i*cmt_pkg::MCR_W
                + cmt_pkg::MCR_INT_BIT];
            hit_rst[i] = hit[i] && q.mcr[i*cmt_pkg::MCR_W
                + cmt_pkg::MCR_RST_BIT];
            hit_stop[i] = hit[i] && q.mcr[i*cmt_pkg::MCR_W
                + cmt_pkg::MCR_STOP_BIT];
            cap_hit[i] = (cap_rise[i] && q.ccr[i*cmt_pkg::CCR_W
                + cmt_pkg::CCR_RISE_BIT])
                || (cap_fall[i] && q.ccr[i*cmt_pkg::CCR_W
                + cmt_pkg::CCR_FALL_BIT]);
        end
    end

    // ============================================================
    // Read multiplexer, unmapped addresses read as zero
    always_comb begin
        rd_val = 32'h0;
        case (i_bus.addr)
            cmt_pkg::ADDR_CTRL: begin
                rd_val[cmt_pkg::CTRL_EN_BIT] = q.en;
                rd_val[cmt_pkg::CTRL_RST_BIT] = q.crst;
            end
            cmt_pkg::ADDR_TC: rd_val = q.tc;
            cmt_pkg::ADDR_PR: rd_val = q.pr;
            cmt_pkg::ADDR_PC: rd_val = q.pc;
            cmt_pkg::ADDR_MCR: rd_val[11:0] = q.mcr;
            cmt_pkg::ADDR_EMR: begin
                rd_val[7:0] = q.emr;
                rd_val[cmt_pkg::EMR_OUT_LSB +: 4] = q.mo;
            end
            cmt_pkg::ADDR_CCR: rd_val[11:0] = q.ccr;
            cmt_pkg::ADDR_STAT: rd_val[7:0] = q.stat;
            cmt_pkg::ADDR_MASK: rd_val[7:0] = q.mask;
            default: begin
                for (int i = 0; i < cmt_pkg::NCH; i++) begin
                    if (i_bus.addr == cmt_pkg::ADDR_MR0
                        + 8'(i) * cmt_pkg::ADDR_STEP) begin
                        rd_val = q.mr[i];
                    end
                    if (i_bus.addr == cmt_pkg::ADDR_CR0
                        + 8'(i) * cmt_pkg::ADDR_STEP) begin
                        rd_val = q.cr[i];
                    end
                end
            end
        endcase
    end

    // ============================================================
    // Next state: writes first, then hardware events on top
    // Hardware sets come last so a set wins over a same-cycle clear
    always_comb begin
        nxt_q = q;
        // Register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                cmt_pkg::ADDR_CTRL: begin
                    nxt_q.en = i_bus.wdata[cmt_pkg::CTRL_EN_BIT];
                    nxt_q.crst = i_bus.wdata[cmt_pkg::CTRL_RST_BIT];
                end
                cmt_pkg::ADDR_PR: nxt_q.pr = i_bus.wdata;
                cmt_pkg::ADDR_MCR: nxt_q.mcr = i_bus.wdata[11:0];
                cmt_pkg::ADDR_EMR: nxt_q.emr = i_bus.wdata[7:0];
                cmt_pkg::ADDR_CCR: nxt_q.ccr = i_bus.wdata[11:0];
                cmt_pkg::ADDR_STAT: begin
                    nxt_q.stat = q.stat & ~i_bus.wdata[7:0];
                end
                cmt_pkg::ADDR_MASK: nxt_q.mask = i_bus.wdata[7:0];
                default: begin
                    for (int i = 0; i < cmt_pkg::NCH; i++) begin
                        if (i_bus.addr == cmt_pkg::ADDR_MR0
                            + 8'(i) * cmt_pkg::ADDR_STEP) begin
                            nxt_q.mr[i] = i_bus.wdata;
                        end
                    end
                end
            endcase
        end
        // Prescale and timer counters
        if (q.crst) begin
            nxt_q.tc = 32'h0;
            nxt_q.pc = 32'h0;
        end else if (wrap) begin
            nxt_q.pc = 32'h0;
            if (|hit_rst) begin
                nxt_q.tc = 32'h0;
            end else if (|hit_stop) begin
                nxt_q.tc = q.tc;
            end else begin
                nxt_q.tc = q.tc + 32'h1;
            end
        end else if (cnt_run) begin
            nxt_q.pc = q.pc + 32'h1;
        end
        // Stop on match beats a same-cycle enable write
        if (|hit_stop) begin
            nxt_q.en = 1'b0;
        end
        // Match outputs and match interrupt flags
        for (int i = 0; i < cmt_pkg::NCH; i++) begin
            if (hit[i]) begin
                unique case (cmt_pkg::match_act_t'(
                    q.emr[i*cmt_pkg::EMR_W +: cmt_pkg::EMR_W]))
                    cmt_pkg::MO_NONE: nxt_q.mo[i] = q.mo[i];
                    cmt_pkg::MO_LOW: nxt_q.mo[i] = 1'b0;
                    cmt_pkg::MO_HIGH: nxt_q.mo[i] = 1'b1;
                    cmt_pkg::MO_TOGGLE: nxt_q.mo[i] = !q.mo[i];
                endcase
            end
            if (hit_int[i]) begin
                nxt_q.stat[cmt_pkg::STAT_MATCH_LSB + i] = 1'b1;
            end
        end
        // Captures take the count as it stands in this cycle
        for (int i = 0; i < cmt_pkg::NCH; i++) begin
            if (cap_hit[i]) begin
                nxt_q.cr[i] = q.tc;
                if (q.ccr[i*cmt_pkg::CCR_W + cmt_pkg::CCR_INT_BIT]) begin
                    nxt_q.stat[cmt_pkg::STAT_CAP_LSB + i] = 1'b1;
                end
            end
        end
        // Read data stand one cycle only, zero otherwise
        nxt_q.rdata = i_bus.rd ? rd_val : 32'h0;
        nxt_q.irq = |(nxt_q.stat & nxt_q.mask);
    end

    // ============================================================
    // State register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            q <= cmt_pkg::TMR_RST;
        end else begin
            q <= nxt_q;
        end
    end

    // Outputs straight from flip-flops
    assign o_rd_data = q.rdata;
    assign o_irq = q.irq;
    assign o_match_output = q.mo;

    // ============================================================
    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_TC_HOLD_NO_TICK: assert property (
        !i_tmr_tick && !q.crst |=> $stable(q.tc) && $stable(q.pc))
        else $error("counter moved without a timer tick");

    AST_PC_WRAP: assert property (
        cnt_run && !q.crst && q.pc == q.pr |=> q.pc == 32'h0)
        else $error("prescaler did not wrap at its limit");

    AST_PC_STEP: assert property (
        cnt_run && q.pc != q.pr |=> q.pc == $past(q.pc) + 32'h1
            && $stable(q.tc))
        else $error("prescaler step wrong or count moved");

    AST_TC_INC: assert property (
        wrap && hit_rst == 4'h0 && hit_stop == 4'h0
            |=> q.tc == $past(q.tc) + 32'h1)
        else $error("count did not step on prescaler wrap");

    AST_MATCH_RESET: assert property (
        |hit_rst |=> q.tc == 32'h0)
        else $error("reset on match did not clear count");

    AST_MATCH_STOP: assert property (
        |hit_stop && hit_rst == 4'h0 |=> !q.en && $stable(q.tc)
            ##1 (!q.en || $past(i_bus.wr)))
        else $error("stop on match did not halt counter");

    AST_MATCH_INT: assert property (
        hit_int[0] |=> q.stat[cmt_pkg::STAT_MATCH_LSB]
            && (q.irq || !q.mask[cmt_pkg::STAT_MATCH_LSB]))
        else $error("match flag or interrupt missing");

    AST_CAPTURE: assert property (
        cap_hit[1] |=> q.cr[1] == $past(q.tc))
        else $error("capture register missed the count");

    AST_CAP_INT: assert property (
        cap_hit[2] && q.ccr[2*cmt_pkg::CCR_W + cmt_pkg::CCR_INT_BIT]
            |=> q.stat[cmt_pkg::STAT_CAP_LSB + 2])
        else $error("capture flag not set");

    AST_MATCH_TOGGLE: assert property (
        hit[3] && q.emr[7:6] == cmt_pkg::MO_TOGGLE
            |=> o_match_output[3] != $past(o_match_output[3]))
        else $error("match output did not toggle");

    AST_MATCH_LOW: assert property (
        hit[0] && q.emr[1:0] == cmt_pkg::MO_LOW
            |=> !o_match_output[0])
        else $error("match output not driven low");

    AST_READ_TC: assert property (
        i_bus.rd && i_bus.addr == cmt_pkg::ADDR_TC
            |=> o_rd_data == $past(q.tc) ##1 (o_rd_data == 32'h0
            || $past(i_bus.rd)))
        else $error("count read data wrong or held too long");

    COV_CAPTURE: cover property (cap_hit[0] ##1 q.irq);
    COV_MATCH_RESET: cover property (|hit_rst ##[1:20] wrap);
    COV_MATCH_STOP: cover property (|hit_stop ##1 !q.en);
    COV_TOGGLE: cover property (hit[3] ##[1:50] hit[3]);

endmodule

`default_nettype wire

// ---- logic/capture_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module capture_sync (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_tick, // Timer branch clock enable
    input wire logic i_in, // Raw capture input
    output logic o_rise, // Rising edge seen, one cycle
    output logic o_fall // Falling edge seen, one cycle
);

    cmt_pkg::sync_state_t q;
    cmt_pkg::sync_state_t nxt_q;

    // ============================================================
    // Two-stage synchroniser, edge taken after the second stage
    // Sampling only on timer ticks keeps captures tied to a stable count
    always_comb begin
        nxt_q = q;
        if (i_tick) begin
            nxt_q.s1 = i_in;
            nxt_q.s2 = q.s1;
            nxt_q.prev = q.s2;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            q <= cmt_pkg::SYNC_RST;
        end else begin
            q <= nxt_q;
        end
    end

    // Edges are single pulses since prev follows s2 on the next tick
    assign o_rise = i_tick && q.s2 && !q.prev;
    assign o_fall = i_tick && !q.s2 && q.prev;

    // ============================================================
    // Checks
    AST_SYNC_LATENCY: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        o_rise |-> q.prev == 1'b0 && q.s2 == 1'b1 ##1 !o_rise)
        else $error("capture edge not a single synchronised pulse");

endmodule

`default_nettype wire

// ---- tb/cap_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Far-side pins: capture sources and match output watcher
module cap_pin_model (
    input wire logic i_sys_clk, // Clock
    input wire logic [3:0] i_level, // Requested capture levels
    input wire logic [3:0] i_match_output, // Match outputs seen
    output logic [3:0] o_capture_input, // Capture pins
    output logic [3:0][7:0] o_edges // Edges seen per output
);
    logic [3:0] last_mo;

    // Pins move just after an edge, unrelated to the timer tick
    always @(posedge i_sys_clk) begin
        o_capture_input <= i_level;
        last_mo <= i_match_output;
        for (int i = 0; i < 4; i++) begin
            if (last_mo[i] !== i_match_output[i]) begin
                o_edges[i] <= o_edges[i] + 8'h01;
            end
        end
    end

    // Known start so the edge count is not fooled by power-up
    initial begin
        o_capture_input = 4'h0;
        o_edges = '0;
        last_mo = 4'h0;
    end
endmodule
`default_nettype wire

// ---- tb/tb_capture_match_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Bench for the capture and match timer
module tb_capture_match_timer;
    logic sys_clk, rst_n, tick, irq;
    cmt_pkg::reg_req_t bus;
    logic [3:0] cap_in, level, mo;
    logic [31:0] rd_data, q;
    logic [3:0][7:0] edges;
    logic [7:0] e0, e3;
    logic [7:0] emr_tab [2] = '{8'h3a, 8'hbd};
    logic [3:0] mo_tab [2] = '{4'h7, 4'h8};
    logic [31:0] cr_a [4] = '{32'h7, 32'h0, 32'h7, 32'h0};
    logic [31:0] cr_b [4] = '{32'h7, 32'hc, 32'hc, 32'h0};
    int mismatches, check_count, cyc, n;

    capture_match_timer u_capture_match_timer (.i_sys_clk(sys_clk),
        .i_rst_n(rst_n), .i_tmr_tick(tick), .i_bus(bus),
        .i_capture_input(cap_in), .o_rd_data(rd_data), .o_irq(irq),
        .o_match_output(mo));
    cap_pin_model u_cap_pin_model (.i_sys_clk(sys_clk), .i_level(level),
        .i_match_output(mo), .o_capture_input(cap_in), .o_edges(edges));

    always #4 sys_clk = ~sys_clk;

    // Hang guard, about ten times the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            $display("[ERR] run expected done seen timeout");
            tally_and_finish();
        end
    end

    // ============================================================
    // Access and compare tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One strobe cycle, then an idle cycle; read data sampled just after the strobe
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        bus <= {w, ~w, a, d};
        @(posedge sys_clk);
        bus <= '0;
        #1 q = rd_data;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        tick = 1'b1;
        bus = '0;
        level = 4'h0;
        idle(20);
        rst_n <= 1'b1;
        idle(1);
        // Whole map and an unmapped word read zero; count is read-only
        for (int a = 0; a <= 'h40; a += 4) begin
            rdc("reg", 8'(a), 32'h0);
        end
        rdc("unmapped", 8'h80, 32'h0);
        wr(cmt_pkg::ADDR_TC, 32'h1234);
        rdc("tc_ro", cmt_pkg::ADDR_TC, 32'h0);
        $display("test reset_values done");

        // Prescale of three ticks, stop at five; time to interrupt
        wr(cmt_pkg::ADDR_PR, 32'h2);
        wr(cmt_pkg::ADDR_MR0, 32'h5);
        wr(cmt_pkg::ADDR_MCR, 32'h5);
        wr(cmt_pkg::ADDR_MASK, 32'h1);
        wr(cmt_pkg::ADDR_CTRL, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq_delay", 32'(n >= 17 && n <= 20), 32'h1);
        idle(10);
        rdc("tc_stop", cmt_pkg::ADDR_TC, 32'h5);
        rdc("ctrl_stop", cmt_pkg::ADDR_CTRL, 32'h0);
        rdc("pc_stop", cmt_pkg::ADDR_PC, 32'h0);
        rdc("stat", cmt_pkg::ADDR_STAT, 32'h1);
        wr(cmt_pkg::ADDR_MASK, 32'h0);
        idle(2);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(cmt_pkg::ADDR_MASK, 32'h1);
        idle(2);
        chk("irq_unmasked", 32'(irq), 32'h1);
        wr(cmt_pkg::ADDR_STAT, 32'h1);
        idle(2);
        chk("irq_cleared", 32'(irq), 32'h0);
        rdc("stat_clr", cmt_pkg::ADDR_STAT, 32'h0);
        $display("test prescale_stop done");

        // All four output actions over two runs of one match each, stop held by channel 3
        wr(cmt_pkg::ADDR_PR, 32'h0);
        wr(cmt_pkg::ADDR_MCR, 32'ha49);
        for (int i = 0; i < 4; i++) begin
            wr(8'(cmt_pkg::ADDR_MR0 + 4 * i), 32'h2);
        end
        for (int r = 0; r < 2; r++) begin
            wr(cmt_pkg::ADDR_EMR, 32'(emr_tab[r]));
            wr(cmt_pkg::ADDR_STAT, 32'hff);
            wr(cmt_pkg::ADDR_CTRL, 32'h2);
            wr(cmt_pkg::ADDR_CTRL, 32'h1);
            idle(20);
            chk("match_out", 32'(mo), 32'(mo_tab[r]));
            rdc("emr", cmt_pkg::ADDR_EMR,
                {20'h0, mo_tab[r], emr_tab[r]});
            rdc("stat4", cmt_pkg::ADDR_STAT, 32'hf);
            rdc("tc_hit", cmt_pkg::ADDR_TC, 32'h2);
        end
        $display("test match_actions done");

        // Reset at three: outputs 1 and 3 toggle every four ticks
        wr(cmt_pkg::ADDR_MCR, 32'h10);
        wr(cmt_pkg::ADDR_EMR, 32'hcc);
        wr(8'(cmt_pkg::ADDR_MR0 + 4), 32'h3);
        wr(cmt_pkg::ADDR_CTRL, 32'h2);
        e0 = edges[1];
        e3 = edges[3];
        wr(cmt_pkg::ADDR_CTRL, 32'h1);
        idle(40);
        wr(cmt_pkg::ADDR_CTRL, 32'h0);
        idle(2);
        n = int'(8'(edges[1] - e0));
        chk("toggles", 32'(n >= 9 && n <= 11), 32'h1);
        n = int'(8'(edges[3] - e3));
        chk("toggles3", 32'(n >= 9 && n <= 11), 32'h1);
        acc(1'b0, cmt_pkg::ADDR_TC, 32'h0);
        chk("tc_wrap", 32'(q < 32'h4), 32'h1);
        $display("test reset_on_match done");

        // Capture: no tick freezes count, then edges latch stopped count
        wr(cmt_pkg::ADDR_MR0, 32'h7);
        wr(cmt_pkg::ADDR_MCR, 32'h4);
        wr(cmt_pkg::ADDR_EMR, 32'h0);
        wr(cmt_pkg::ADDR_CCR, 32'h1d5);
        wr(cmt_pkg::ADDR_STAT, 32'hff);
        wr(cmt_pkg::ADDR_MASK, 32'hf0);
        tick <= 1'b0;
        wr(cmt_pkg::ADDR_CTRL, 32'h2);
        wr(cmt_pkg::ADDR_CTRL, 32'h1);
        idle(20);
        rdc("tc_notick", cmt_pkg::ADDR_TC, 32'h0);
        tick <= 1'b1;
        idle(20);
        rdc("tc_seven", cmt_pkg::ADDR_TC, 32'h7);
        level <= 4'hf;
        idle(10);
        for (int i = 0; i < 4; i++) begin
            rdc("cr_rise", 8'(cmt_pkg::ADDR_CR0 + 4 * i),
                cr_a[i]);
        end
        rdc("stat_cap", cmt_pkg::ADDR_STAT, 32'h50);
        chk("irq_cap", 32'(irq), 32'h1);
        wr(cmt_pkg::ADDR_MR0, 32'hc);
        wr(cmt_pkg::ADDR_CTRL, 32'h1);
        idle(20);
        level <= 4'h0;
        idle(10);
        for (int i = 0; i < 4; i++) begin
            rdc("cr_fall", 8'(cmt_pkg::ADDR_CR0 + 4 * i),
                cr_b[i]);
        end
        rdc("stat_fall", cmt_pkg::ADDR_STAT, 32'h50);
        $display("test capture done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
